// file: pkg/sleep_wakeup_defs.svh
`ifndef SLEEP_WAKEUP_DEFS_SVH
`define SLEEP_WAKEUP_DEFS_SVH
`define WAKE_VECTOR_ADDR   13'h0004
`define WAKE_DUMMY_CYCLES  2
`define OST_OSC_PERIODS    1024
`define PD_RESET_VALUE     1'b1
`define TO_RESET_VALUE     1'b1
`endif

// file: pkg/sleep_wakeup_pkg.sv
package sleep_wakeup_pkg;
	typedef enum logic [4:0] {
		ST_RUN    = 5'b0_0001,
		ST_SLEEP  = 5'b0_0010,
		ST_OST    = 5'b0_0100,
		ST_RESUME = 5'b0_1000,
		ST_DUMMY  = 5'b1_0000
	} wake_state_t;
	typedef struct packed {
		logic ext_int;
		logic portb_change;
		logic comparator;
	} irq_vec_t;
	typedef struct packed {
		wake_state_t state;
		logic        powerdown_flag;
		logic        timeout_flag;
		logic        vector_pending;
		logic [11:0] count;
		logic        master_clear_pin_s1;
		logic        master_clear_pin_s2;
		logic        wdt_s1;
		logic        wdt_s2;
	} wake_regs_t;
endpackage

// file: src/sleep_wakeup_control.sv
`include "sleep_wakeup_defs.svh"
module sleep_wakeup_control
	import sleep_wakeup_pkg::*;
#(
	parameter int OST_CYCLES   = `OST_OSC_PERIODS,
	parameter int DUMMY_CYCLES = `WAKE_DUMMY_CYCLES
) (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        master_clear_pin,
	input  wire logic        watchdog_wake,
	input  wire logic        watchdog_enable,
	input  wire irq_vec_t    irq_flags,
	input  wire irq_vec_t    irq_enables,
	input  wire logic        global_interrupt_enable,
	input  wire logic        crystal_osc_mode,
	input  wire logic        sleep_exec,
	input  wire logic        wdt_clear_exec,
	input  wire logic        por_event,
	output logic             device_reset,
	output logic             core_stall,
	output logic             osc_enable,
	output logic             watchdog_counter_clear,
	output logic             prefetch_next,
	output logic             exec_after_sleep,
	output logic             vector_fetch,
	output logic [12:0]      vector_addr,
	output logic             powerdown_flag,
	output logic             timeout_flag,
	output logic             asleep
);
	initial begin
		if (OST_CYCLES < 1 || OST_CYCLES > 4095 || DUMMY_CYCLES < 1 || DUMMY_CYCLES > 4095)
			$error("sleep_wakeup_control: unsupported count parameter");
	end

	wake_regs_t r;
	wake_regs_t next_r;
	logic       irq_wake;
	logic       wdt_wake;
	logic       master_clear_pin_low;

	function automatic logic any_enabled(input irq_vec_t f, input irq_vec_t e);
		any_enabled = |(f & e);
	endfunction

	assign irq_wake = any_enabled(irq_flags, irq_enables);
	assign wdt_wake = r.wdt_s2 && watchdog_enable;
	assign master_clear_pin_low = !r.master_clear_pin_s2;

	always_comb begin
		next_r                 = r;
		next_r.master_clear_pin_s1         = master_clear_pin;
		next_r.master_clear_pin_s2         = r.master_clear_pin_s1;
		next_r.wdt_s1          = watchdog_wake;
		next_r.wdt_s2          = r.wdt_s1;
		watchdog_counter_clear = 1'b0;
		case (r.state)
			ST_RUN: begin
				if (sleep_exec) begin
					// sleep completes even when a wake is already pending
					next_r.state          = ST_SLEEP;
					next_r.powerdown_flag = 1'b0;
					next_r.timeout_flag   = 1'b1;
					watchdog_counter_clear = 1'b1;
				end
			end
			ST_SLEEP: begin
				if (wdt_wake || irq_wake) begin
					watchdog_counter_clear = 1'b1;
					if (wdt_wake)
						next_r.timeout_flag = 1'b0;
					next_r.vector_pending = global_interrupt_enable && irq_wake;
					next_r.count          = 12'h0000;
					next_r.state          = crystal_osc_mode ? ST_OST : ST_RESUME;
				end
			end
			ST_OST: begin
				next_r.count = r.count + 12'h0001;
				if (r.count == 12'(OST_CYCLES - 1)) begin
					next_r.count = 12'h0000;
					next_r.state = ST_RESUME;
				end
			end
			ST_RESUME: begin
				// the prefetched instruction executes here
				next_r.state = r.vector_pending ? ST_DUMMY : ST_RUN;
			end
			ST_DUMMY: begin
				next_r.count = r.count + 12'h0001;
				if (r.count == 12'(DUMMY_CYCLES - 1)) begin
					next_r.count          = 12'h0000;
					next_r.vector_pending = 1'b0;
					next_r.state          = ST_RUN;
				end
			end
			default: next_r.state = ST_RUN;
		endcase
		// setting the flags wins over a clear in the same cycle
		if (wdt_clear_exec) begin
			next_r.timeout_flag   = 1'b1;
			next_r.powerdown_flag = 1'b1;
		end
		if (por_event) begin
			next_r.powerdown_flag = 1'b1;
			next_r.timeout_flag   = 1'b1;
		end
		if (master_clear_pin_low) begin
			// master clear restarts the core, asleep or not
			next_r.state          = ST_RUN;
			next_r.vector_pending = 1'b0;
			next_r.count          = 12'h0000;
			if (r.state != ST_RUN)
				watchdog_counter_clear = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			r                <= '0;
			r.state          <= ST_RUN;
			r.powerdown_flag <= `PD_RESET_VALUE;
			r.timeout_flag   <= `TO_RESET_VALUE;
			r.master_clear_pin_s1        <= 1'b1;
			r.master_clear_pin_s2        <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign device_reset     = master_clear_pin_low;
	assign asleep           = (r.state == ST_SLEEP);
	assign osc_enable       = (r.state != ST_SLEEP);
	assign core_stall       = (r.state == ST_SLEEP) || (r.state == ST_OST) || (r.state == ST_DUMMY);
	assign prefetch_next    = (r.state == ST_RUN) && sleep_exec;
	assign exec_after_sleep = (r.state == ST_RESUME);
	assign vector_fetch     = (r.state == ST_DUMMY) && (r.count == 12'(DUMMY_CYCLES - 1));
	assign vector_addr      = `WAKE_VECTOR_ADDR;
	assign powerdown_flag   = r.powerdown_flag;
	assign timeout_flag     = r.timeout_flag;

	property p_sleep_clears_pd;
		@(posedge sys_clk) disable iff (!rstn)
		(r.state == ST_RUN && sleep_exec && !por_event && !wdt_clear_exec && !master_clear_pin_low)
			|=> (!powerdown_flag && timeout_flag && asleep);
	endproperty
	a_sleep_clears_pd: assert property (p_sleep_clears_pd) else $error("sleep entry flags wrong");

	property p_wdt_wake_to;
		@(posedge sys_clk) disable iff (!rstn)
		(asleep && wdt_wake && !master_clear_pin_low && !por_event && !wdt_clear_exec) |=> !timeout_flag;
	endproperty
	a_wdt_wake_to: assert property (p_wdt_wake_to) else $error("timeout flag not cleared");

	property p_wake_clears_wdt;
		@(posedge sys_clk) disable iff (!rstn)
		(asleep && (wdt_wake || irq_wake)) |-> watchdog_counter_clear;
	endproperty
	a_wake_clears_wdt: assert property (p_wake_clears_wdt) else $error("watchdog not cleared");

	property p_no_wake_without_enable;
		@(posedge sys_clk) disable iff (!rstn)
		(asleep && !wdt_wake && !irq_wake && !master_clear_pin_low) |=> asleep;
	endproperty
	a_no_wake_without_enable: assert property (p_no_wake_without_enable) else $error("spurious wake");

	sequence s_rc_wake;
		asleep && irq_wake && !wdt_wake && !master_clear_pin_low && !crystal_osc_mode;
	endsequence
	property p_rc_resume;
		@(posedge sys_clk) disable iff (!rstn)
		s_rc_wake |=> exec_after_sleep;
	endproperty
	a_rc_resume: assert property (p_rc_resume) else $error("rc wake did not resume");

	property p_inline_no_vector;
		@(posedge sys_clk) disable iff (!rstn)
		(exec_after_sleep && !r.vector_pending && !master_clear_pin_low) |=> (r.state == ST_RUN);
	endproperty
	a_inline_no_vector: assert property (p_inline_no_vector) else $error("vectored when disabled");

	property p_vector_after_dummy;
		@(posedge sys_clk) disable iff (!rstn)
		(exec_after_sleep && r.vector_pending && !master_clear_pin_low)
			|=> (r.state == ST_DUMMY) ##0 (!vector_fetch || DUMMY_CYCLES == 1);
	endproperty
	a_vector_after_dummy: assert property (p_vector_after_dummy) else $error("no dummy cycle");

	property p_master_clear_pin_reset;
		@(posedge sys_clk) disable iff (!rstn)
		master_clear_pin_low |-> device_reset ##1 (r.state == ST_RUN);
	endproperty
	a_master_clear_pin_reset: assert property (p_master_clear_pin_reset) else $error("master clear not reset");

	property p_osc_off_asleep;
		@(posedge sys_clk) disable iff (!rstn)
		asleep |-> (!osc_enable && core_stall);
	endproperty
	a_osc_off_asleep: assert property (p_osc_off_asleep) else $error("oscillator on in sleep");

	property p_prefetch;
		@(posedge sys_clk) disable iff (!rstn)
		(r.state == ST_RUN && sleep_exec) |-> prefetch_next;
	endproperty
	a_prefetch: assert property (p_prefetch) else $error("no prefetch");

	property p_por_sets_flags;
		@(posedge sys_clk) disable iff (!rstn)
		por_event |=> (powerdown_flag && timeout_flag);
	endproperty
	a_por_sets_flags: assert property (p_por_sets_flags) else $error("flags not set");

	property p_resume_no_reset;
		@(posedge sys_clk) disable iff (!rstn)
		exec_after_sleep |-> (!device_reset && !core_stall && !asleep);
	endproperty
	a_resume_no_reset: assert property (p_resume_no_reset) else $error("resume broken");

	sequence s_xtal_wake;
		asleep && (irq_wake || wdt_wake) && !master_clear_pin_low && crystal_osc_mode;
	endsequence
	sequence s_xtal_hold;
		core_stall && !exec_after_sleep && !asleep;
	endsequence
	property p_xtal_wait;
		@(posedge sys_clk) disable iff (!rstn)
		s_xtal_wake |=> s_xtal_hold;
	endproperty
	a_xtal_wait: assert property (p_xtal_wait) else $error("no startup wait");

	property p_vector_addr;
		@(posedge sys_clk) disable iff (!rstn)
		vector_fetch |-> (vector_addr == `WAKE_VECTOR_ADDR && core_stall);
	endproperty
	a_vector_addr: assert property (p_vector_addr) else $error("bad vector fetch");

	property p_sleep_clears_wdt;
		@(posedge sys_clk) disable iff (!rstn)
		(r.state == ST_RUN && sleep_exec) |-> watchdog_counter_clear;
	endproperty
	a_sleep_clears_wdt: assert property (p_sleep_clears_wdt) else $error("no clear on sleep");

	property p_irq_wakes;
		@(posedge sys_clk) disable iff (!rstn)
		(asleep && irq_wake && !master_clear_pin_low) |=> !asleep;
	endproperty
	a_irq_wakes: assert property (p_irq_wakes) else $error("irq did not wake");

	property p_pending_sleep;
		@(posedge sys_clk) disable iff (!rstn)
		(r.state == ST_RUN && sleep_exec && irq_wake && !master_clear_pin_low) |=> asleep;
	endproperty
	a_pending_sleep: assert property (p_pending_sleep) else $error("sleep not completed");

	property p_dummy_stall;
		@(posedge sys_clk) disable iff (!rstn)
		(r.state == ST_DUMMY) |-> (core_stall && !exec_after_sleep);
	endproperty
	a_dummy_stall: assert property (p_dummy_stall) else $error("dummy not stalled");

	property p_osc_on_awake;
		@(posedge sys_clk) disable iff (!rstn)
		!asleep |-> osc_enable;
	endproperty
	a_osc_on_awake: assert property (p_osc_on_awake) else $error("oscillator off awake");

	property p_exec_one_cycle;
		@(posedge sys_clk) disable iff (!rstn)
		exec_after_sleep |=> !exec_after_sleep;
	endproperty
	a_exec_one_cycle: assert property (p_exec_one_cycle) else $error("resume too long");

	property p_master_clear_pin_clears_wdt;
		@(posedge sys_clk) disable iff (!rstn)
		(asleep && master_clear_pin_low) |-> watchdog_counter_clear;
	endproperty
	a_master_clear_pin_clears_wdt: assert property (p_master_clear_pin_clears_wdt) else $error("no clear on reset");

	property p_wdt_needs_enable;
		@(posedge sys_clk) disable iff (!rstn)
		(asleep && r.wdt_s2 && !watchdog_enable && !irq_wake && !master_clear_pin_low) |=> asleep;
	endproperty
	a_wdt_needs_enable: assert property (p_wdt_needs_enable) else $error("disabled wdt woke");
endmodule

// file: verif/core_fetch_model.sv
module core_fetch_model (
	input  wire logic sys_clk,
	input  wire logic sleep_req,
	input  wire logic core_stall,
	output logic      sleep_exec
);
	timeunit 1ns;
	timeprecision 1ns;
	initial sleep_exec = 1'b0;
	// one-cycle sleep op; the slot after it is a no-op
	always @(negedge sys_clk) sleep_exec <= sleep_req & ~core_stall;
endmodule

// file: verif/test_sleep_wakeup_control.sv
module test_sleep_wakeup_control;
	import sleep_wakeup_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int OST = 4;
	logic        sys_clk, rstn, master_clear_pin, watchdog_wake, watchdog_enable;
	logic        global_interrupt_enable, crystal_osc_mode, sleep_exec, sreq;
	logic        wdt_clear_exec, por_event, device_reset, core_stall, osc_enable;
	logic        watchdog_counter_clear, prefetch_next, exec_after_sleep, vector_fetch;
	logic        powerdown_flag, timeout_flag, asleep;
	irq_vec_t    irq_flags, irq_enables;
	logic [12:0] vector_addr;
	logic [15:0] rs = 16'hECA3;
	int          mismatches, checked;
	sleep_wakeup_control #(.OST_CYCLES(OST)) dut (.sys_clk, .rstn, .master_clear_pin,
		.watchdog_wake, .watchdog_enable, .irq_flags, .irq_enables, .global_interrupt_enable,
		.crystal_osc_mode, .sleep_exec, .wdt_clear_exec, .por_event, .device_reset,
		.core_stall, .osc_enable, .watchdog_counter_clear, .prefetch_next, .exec_after_sleep,
		.vector_fetch, .vector_addr, .powerdown_flag, .timeout_flag, .asleep);
	core_fetch_model core (.sys_clk, .sleep_req(sreq), .core_stall, .sleep_exec);
	function automatic logic [15:0] xs(logic [15:0] v);
		v ^= v << 7;
		v ^= v >> 9;
		v ^= v << 8;
		return v;
	endfunction
	task automatic chk(logic [12:0] seen, logic [12:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// src 0 irq, 1 watchdog, 2 master clear
	task automatic sleep_wake(int src, logic g, logic x, irq_vec_t b);
		int   n;
		logic vs, cs;
		n = 0;
		vs = 0;
		cs = 0;
		global_interrupt_enable <= g;
		crystal_osc_mode <= x;
		sreq <= 1;
		cyc(1);
		sreq <= 0;
		#1 chk(prefetch_next, 1);
		cyc(2);
		chk({asleep, powerdown_flag, timeout_flag, osc_enable, core_stall}, 5'b10101);
		if (src == 2) begin
			master_clear_pin <= 0;
			cyc(4);
			chk(device_reset, 1);
			master_clear_pin <= 1;
			cyc(6);
			chk(device_reset, 0);
			return;
		end
		irq_enables <= b;
		irq_flags <= ~b;
		watchdog_wake <= src == 1;
		watchdog_enable <= 0;
		cyc(6);
		chk(asleep, 1);
		irq_flags <= (src == 0) ? 3'b111 : 3'b000;
		watchdog_enable <= src == 1;
		#1 cs = watchdog_counter_clear;
		while (exec_after_sleep !== 1 && n < 2000) begin
			cyc(1);
			n++;
			cs |= watchdog_counter_clear;
		end
		chk(n >= (x ? OST : 1) && n < (x ? OST : 0) + 6, 1);
		irq_flags <= 0;
		watchdog_wake <= 0;
		repeat (4) begin
			cyc(1);
			vs |= vector_fetch;
		end
		chk(vs, g && src == 0);
		chk({timeout_flag, cs, device_reset, asleep, core_stall}, {src == 0, 4'b1000});
		$display("wake test src %0d done", src);
	endtask
	initial begin
		sys_clk = 0;
		forever #20 sys_clk = ~sys_clk;
	end
	initial begin
		#200000;
		mismatches++;
		complete_run;
	end
	initial begin
		{rstn, watchdog_wake, watchdog_enable, global_interrupt_enable, sreq} = 0;
		{crystal_osc_mode, wdt_clear_exec, por_event, irq_flags, irq_enables} = 0;
		master_clear_pin = 1;
		cyc(16);
		rstn <= 1;
		cyc(2);
		chk({powerdown_flag, timeout_flag}, 2'b11);
		chk(vector_addr, 13'h0004);
		irq_enables <= 3'b001;
		irq_flags <= 3'b001;
		sreq <= 1;
		cyc(1);
		sreq <= 0;
		cyc(5);
		chk({asleep, powerdown_flag}, 2'b00);
		irq_flags <= 0;
		cyc(2);
		sleep_wake(2, 0, 0, 3'b010);
		por_event <= 1;
		cyc(1);
		por_event <= 0;
		cyc(1);
		chk({powerdown_flag, timeout_flag}, 2'b11);
		sleep_wake(0, 1, 1, 3'b100);
		sleep_wake(1, 1, 0, 3'b001);
		for (int i = 0; i < 12; i++) begin
			rs = xs(rs);
			sleep_wake(rs[1:0] == 3 ? 0 : rs[1:0], rs[2], rs[3], 3'b100 >> (rs[5:4] % 3));
		end
		sleep_wake(0, 0, 0, 3'b010);
		wdt_clear_exec <= 1;
		cyc(1);
		wdt_clear_exec <= 0;
		cyc(1);
		chk({powerdown_flag, timeout_flag}, 2'b11);
		complete_run;
	end
endmodule
